// ### verilog/sera_top.sv
// Serial EEPROM target: acknowledge polling, reads, address pointer.
// Assumes an outside write engine raising prog_busy while programming,
// and an array whose mem_rdata follows mem_addr within the same mclk.
//
// Operation
// - No acknowledge to any control byte while programming runs.
// - After programming, the poll control byte is acknowledged.
// - Reads start like writes, direction bit set to one.
// - Pointer holds last accessed location plus one.
// - Matching read byte acknowledged, then data shifted out MSB first.
// - A missing acknowledge from the controller ends transmission.
// - Word address loads the pointer before a repeated START.
// - After a random read the pointer is past the returned byte.
// - Controller acknowledge causes the next sequential byte to go out.
// - Pointer steps by one per byte and wraps 7F to 00.
// - Respond only to code 1010 and matching chip selects.
// - Byte after a write control byte is the word address.
// - On a missing acknowledge the data line is released high.
`default_nettype none

module sera_top
  import sera_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] chip_select_inputs,
  input wire logic prog_busy,
  output logic [ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [DATA_W-1:0] mem_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_pipe;
  logic sys_rst_n;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign sys_rst_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////
  // Link side state, clocked by the bus clock

  logic start_tgl;
  logic stop_tgl;

  sera_cond_det u_cond
  (
    .rst_n(sys_rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .start_tgl(start_tgl),
    .stop_tgl(stop_tgl)
  );

  sera_lstate_t lstate, next_state;
  logic [3:0] bit_cnt, next_cnt;
  logic [DATA_W-1:0] shreg, next_sh;
  logic [DATA_W-1:0] txbyte, next_txbyte;
  logic [DATA_W-1:0] pre, next_pre;
  logic [ADDR_W-1:0] ptr, next_ptr;
  logic ack_pend, next_ack_pend;
  logic tx, next_tx;
  logic fetch_req, next_req;
  logic start_ack, stop_ack;
  logic ack_seen, next_ack_seen;
  logic busy_p0, busy_s;
  logic [2:0] cs_p0, cs_s;
  logic ack_p0, ack_s;
  logic fetch_ack;
  logic [DATA_W-1:0] rdata_hold;
  logic [DATA_W-1:0] byte_in;
  logic ctrl_match;
  logic load;
  logic next_oe;

  // Data is sampled straight off the pin: the bus keeps it steady
  // around the clock's rising edge, so no synchroniser is needed.
  assign byte_in = {shreg[6:0], sda_in};
  assign ctrl_match = (byte_in[7:4] == CTRL_CODE) &&
                      (byte_in[3:1] == cs_s);

  always_comb
  begin
    next_state = lstate;
    next_cnt = bit_cnt;
    next_sh = shreg;
    next_txbyte = txbyte;
    next_ptr = ptr;
    next_ack_pend = ack_pend;
    next_tx = tx;
    next_req = fetch_req;
    next_ack_seen = ack_s;
    next_pre = (ack_s != ack_seen) ? rdata_hold : pre;
    load = 1'b0;
    if (start_tgl != start_ack)
    begin
      next_state = LS_CTRL;
      next_cnt = BIT_FIRST;
      next_sh = {7'h00, sda_in};
      next_ack_pend = 1'b0;
      next_tx = 1'b0;
    end
    else if (stop_tgl != stop_ack)
    begin
      next_state = LS_IDLE;
      next_ack_pend = 1'b0;
      next_tx = 1'b0;
    end
    else if (lstate != LS_IDLE)
    begin
      if (bit_cnt == BIT_ACK)
      begin
        next_cnt = 4'h0;
        next_ack_pend = 1'b0;
        case (lstate)
          LS_CTRL:
          begin
            if (!ack_pend)
              next_state = LS_IDLE;
            else if (shreg[0] == RW_READ)
            begin
              next_state = LS_TX;
              load = 1'b1;
            end
            else
              next_state = LS_ADDR;
          end
          LS_ADDR:
          begin
            next_ptr = shreg[ADDR_W-1:0];
            next_req = ~fetch_req;
            next_state = LS_IGN;
          end
          LS_TX:
          begin
            if (!sda_in)
              load = 1'b1;
            else
            begin
              next_state = LS_IDLE;
              next_tx = 1'b0;
            end
          end
          default:
            next_state = lstate;
        endcase
      end
      else
      begin
        next_cnt = bit_cnt + 4'h1;
        next_sh = byte_in;
        if (bit_cnt == BIT_LAST)
        begin
          case (lstate)
            LS_CTRL: next_ack_pend = ctrl_match && !busy_s;
            LS_ADDR: next_ack_pend = 1'b1;
            default: next_ack_pend = 1'b0;
          endcase
        end
      end
    end
    if (load)
    begin
      next_tx = 1'b1;
      next_txbyte = pre;
      next_ptr = ptr + PTR_STEP;
      next_req = ~fetch_req;
    end
  end

  always_ff @(posedge scl or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      lstate <= LS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txbyte <= 8'h00;
      pre <= 8'h00;
      ptr <= PTR_RESET;
      ack_pend <= 1'b0;
      tx <= 1'b0;
      fetch_req <= 1'b0;
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
      ack_seen <= 1'b0;
    end
    else
    begin
      lstate <= next_state;
      bit_cnt <= next_cnt;
      shreg <= next_sh;
      txbyte <= next_txbyte;
      pre <= next_pre;
      ptr <= next_ptr;
      ack_pend <= next_ack_pend;
      tx <= next_tx;
      fetch_req <= next_req;
      start_ack <= start_tgl;
      stop_ack <= stop_tgl;
      ack_seen <= next_ack_seen;
    end
  end

  // Synchronisers into the link domain
  always_ff @(posedge scl or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      busy_p0 <= 1'b1;
      busy_s <= 1'b1;
      cs_p0 <= 3'h0;
      cs_s <= 3'h0;
      ack_p0 <= 1'b0;
      ack_s <= 1'b0;
    end
    else
    begin
      busy_p0 <= prog_busy;
      busy_s <= busy_p0;
      cs_p0 <= chip_select_inputs;
      cs_s <= cs_p0;
      ack_p0 <= fetch_ack;
      ack_s <= ack_p0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line driver, changes only while the clock is low

  always_comb
  begin
    if (bit_cnt == BIT_ACK)
      next_oe = ack_pend;
    else
      next_oe = tx && !txbyte[~bit_cnt[2:0]];
  end

  always_ff @(negedge scl or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
      sda_oe <= 1'b0;
    else
      sda_oe <= next_oe;
  end

  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Array fetch on the system clock, toggle handshake with the link

  logic [2:0] req_p;
  logic boot, next_boot;
  logic fetch_go;
  logic next_rd;
  logic next_fetch_ack;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_hold;

  // Boot fetch fills the prefetch for the reset pointer value
  assign fetch_go = (req_p[2] != req_p[1]) || boot;

  always_comb
  begin
    next_boot = 1'b0;
    next_rd = fetch_go;
    next_mem_addr = fetch_go ? ptr : mem_addr;
    next_hold = mem_rd ? mem_rdata : rdata_hold;
    next_fetch_ack = mem_rd ? ~fetch_ack : fetch_ack;
  end

  always_ff @(posedge mclk or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      req_p <= 3'h0;
      boot <= 1'b1;
      mem_rd <= 1'b0;
      mem_addr <= PTR_RESET;
      rdata_hold <= 8'h00;
      fetch_ack <= 1'b0;
    end
    else
    begin
      req_p <= {req_p[1:0], fetch_req};
      boot <= next_boot;
      mem_rd <= next_rd;
      mem_addr <= next_mem_addr;
      rdata_hold <= next_hold;
      fetch_ack <= next_fetch_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence ctrl_last_s;
    lstate == LS_CTRL && bit_cnt == BIT_LAST && start_tgl == start_ack &&
      stop_tgl == stop_ack;
  endsequence

  sequence tx_ack_slot_s;
    lstate == LS_TX && bit_cnt == BIT_ACK && start_tgl == start_ack &&
      stop_tgl == stop_ack;
  endsequence

  busy_no_ack_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    ctrl_last_s and busy_s |=> !sda_oe)
    else $error("control byte acknowledged while programming");

  ctrl_ack_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    ctrl_last_s and ctrl_match && !busy_s |=> sda_oe)
    else $error("matching control byte not acknowledged");

  foreign_nack_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    ctrl_last_s and !ctrl_match |=> !sda_oe)
    else $error("foreign control byte acknowledged");

  read_start_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    ctrl_last_s and ctrl_match && !busy_s && sda_in == RW_READ
      |=> ##1 tx && lstate == LS_TX)
    else $error("read did not begin after acknowledge");

  addr_load_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    lstate == LS_ADDR && bit_cnt == BIT_ACK && ack_pend &&
      start_tgl == start_ack && stop_tgl == stop_ack
      |=> ptr == $past(shreg[ADDR_W-1:0]))
    else $error("word address not loaded into pointer");

  ptr_step_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    load |=> ptr == ADDR_W'($past(ptr) + PTR_STEP))
    else $error("pointer did not step by one");

  msb_first_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    load |=> sda_oe == !$past(pre[DATA_W-1]))
    else $error("first data bit is not the MSB");

  nack_release_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    tx_ack_slot_s and sda_in |=> !sda_oe [*8])
    else $error("data line held after missing acknowledge");

  seq_next_a: assert property (@(posedge scl) disable iff (!sys_rst_n)
    tx_ack_slot_s and !sda_in |=> tx && bit_cnt == 4'h0)
    else $error("next byte not sent after acknowledge");

  fetch_turn_a: assert property (@(posedge mclk) disable iff (!sys_rst_n)
    req_p[2] != req_p[1] |=> mem_rd && mem_addr == $past(ptr) ##1
      fetch_ack != $past(fetch_ack))
    else $error("array fetch not completed in two cycles");

endmodule

`default_nettype wire

// ### verilog/sera_pkg.sv
// Constants shared by the serial EEPROM read and poll logic.
// Assumes a 128 x 8 array behind a byte read port on the system clock.
`default_nettype none

package sera_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [ADDR_W-1:0] PTR_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP = 7'h01;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_CTRL,
    LS_ADDR,
    LS_TX,
    LS_IGN
  } sera_lstate_t;

endpackage

`default_nettype wire

// ### verilog/sera_cond_det.sv
// Bus condition detector: START and STOP seen as data edges, clock high.
// Assumes the bus clock is steady around each data edge.
`default_nettype none

module sera_cond_det
(
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic start_tgl,
  output logic stop_tgl
);

  logic next_start_tgl;
  logic next_stop_tgl;

  always_comb
  begin
    next_start_tgl = scl ? ~start_tgl : start_tgl;
    next_stop_tgl = scl ? ~stop_tgl : stop_tgl;
  end

  // Toggles, not pulses: the clock may stop right after a STOP
  always_ff @(negedge sda_in or negedge rst_n)
  begin
    if (!rst_n)
      start_tgl <= 1'b0;
    else
      start_tgl <= next_start_tgl;
  end

  always_ff @(posedge sda_in or negedge rst_n)
  begin
    if (!rst_n)
      stop_tgl <= 1'b0;
    else
      stop_tgl <= next_stop_tgl;
  end

endmodule

`default_nettype wire

// ### bench/sera_ctl_model.sv
// Two-wire bus controller model: START, STOP, byte send and receive.
// Assumes the bench resolves the data wire with a pull-up.
`default_nettype none

module sera_ctl_model
(
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  output logic [7:0] obs_val,
  output logic obs_stb
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int QTR = 40;

  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    obs_val = 8'h00;
    obs_stb = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Each result toggles the strobe; the bench pairs it with a note
  task automatic note(input logic [7:0] v);
    obs_val = v;
    obs_stb = !obs_stb;
  endtask

  task automatic bit_cycle(input logic b, output logic r);
    sda_pull = !b;
    #QTR;
    scl = 1'b1;
    #QTR;
    r = sda;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  // Serves as repeated START too; clock stands low between frames after a byte, high after a STOP
  task automatic start();
    sda_pull = 1'b0;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_pull = 1'b1;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_pull = 1'b0;
    #QTR;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'b1, r);
    ack = !r;
    note({7'h00, ack});
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(!more, r);
    note(d);
  endtask

endmodule

`default_nettype wire

// ### bench/sera_top_tb.sv
// Self-checking bench for the serial EEPROM target: reads and polling.
// Assumes a behavioural array and the bus controller model beside it.
`default_nettype none

module sera_top_tb
  import sera_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst_n, prog_busy, scl, sda_pull, sda_in, sda_oe, obs_stb;
  logic mem_rd, sda_out;
  logic ack;
  logic [2:0] chip_select_inputs;
  logic [7:0] obs_val, rd;
  logic [ADDR_W-1:0] mem_addr, exp_ptr;
  logic [DATA_W-1:0] mem [128];
  logic [DATA_W-1:0] mem_rdata;
  logic [7:0] exp_q [$];
  int miscompares, samples_checked;

  // Open-drain wire with pull-up
  assign sda_in = !(sda_oe | sda_pull);
  // Data valid only during the read strobe, so a missed strobe shows up
  assign mem_rdata = mem_rd ? mem[mem_addr] : 8'hxx;

  sera_top u_sera_top (.mclk(mclk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_inputs(chip_select_inputs), .prog_busy(prog_busy),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  sera_ctl_model u_sera_ctl_model (.scl(scl), .sda_pull(sda_pull),
    .sda(sda_in), .obs_val(obs_val), .obs_stb(obs_stb));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = !mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(obs_stb)
  begin
    if ($time > 0)
      compare(obs_val, exp_q.pop_front());
  end

  task automatic frame(input logic [7:0] cb, input logic want);
    u_sera_ctl_model.start();
    exp_q.push_back({7'h00, want});
    u_sera_ctl_model.send_byte(cb, ack);
  endtask

  task automatic read_n(input int n);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(mem[exp_ptr]);
      exp_ptr = exp_ptr + PTR_STEP;
      u_sera_ctl_model.recv_byte(i < n - 1, rd);
    end
    u_sera_ctl_model.stop();
    compare({7'h00, sda_oe}, 8'h00);
    compare({7'h00, sda_out}, 8'h00);
  endtask

  // Address load by a write frame, then repeated START into a read
  task automatic rand_read(input logic [7:0] a, input int n);
    frame({CTRL_CODE, chip_select_inputs, !RW_READ}, 1'b1);
    exp_q.push_back(8'h01);
    u_sera_ctl_model.send_byte(a, ack);
    exp_ptr = a[6:0];
    frame({CTRL_CODE, chip_select_inputs, RW_READ}, 1'b1);
    read_n(n);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    prog_busy = 1'b0;
    chip_select_inputs = 3'h5;
    void'($urandom(32'h704b));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    exp_ptr = PTR_RESET;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    frame({CTRL_CODE, chip_select_inputs, RW_READ}, 1'b1);
    read_n(2);
    rand_read(8'hfd, 5);
    frame({CTRL_CODE, chip_select_inputs, RW_READ}, 1'b1);
    read_n(1);
    frame({4'hb, chip_select_inputs, RW_READ}, 1'b0);
    u_sera_ctl_model.stop();
    frame({CTRL_CODE, chip_select_inputs ^ 3'h1, RW_READ}, 1'b0);
    u_sera_ctl_model.stop();
    @(posedge mclk);
    prog_busy <= 1'b1;
    repeat (3)
    begin
      frame({CTRL_CODE, chip_select_inputs, !RW_READ}, 1'b0);
    end
    @(posedge mclk);
    prog_busy <= 1'b0;
    frame({CTRL_CODE, chip_select_inputs, !RW_READ}, 1'b1);
    rand_read(8'h7f, 2);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge mclk);
      chip_select_inputs <= 3'($urandom);
      @(posedge mclk);
      rand_read(8'($urandom), 1 + $urandom_range(2));
    end
    compare(8'(exp_q.size()), 8'h00);
    print_verdict();
  end

  // Whole run is about 63 to 75 us of bus traffic
  initial
  begin
    #600000;
    miscompares++;
    print_verdict();
  end

endmodule

`default_nettype wire
